// file: hw/auxc_ctrl.sv
module auxc_ctrl #(
	parameter int FW_T1_CYCLES = auxc_pkg::FW_T1_CYC,
	parameter int FW_T2_CYCLES = auxc_pkg::FW_T2_CYC,
	parameter int FW_T3_CYCLES = auxc_pkg::FW_T3_CYC
) (
	input  wire logic                 clk,
	input  wire logic                 rst,
	input  wire logic [14:0]          avs_address,
	input  wire logic                 avs_read,
	input  wire logic                 avs_write,
	input  wire logic [3:0]           avs_byteenable,
	input  wire logic [31:0]          avs_writedata,
	output logic      [31:0]          avs_readdata,
	output logic                      avs_waitrequest,
	input  wire auxc_pkg::auxc_power_t power_mode,
	input  wire logic [3:0]           adc_channel_select,
	input  wire logic                 adc_conv_done,
	input  wire logic                 bandgap_auto_req,
	input  wire logic                 flash_write_busy,
	input  wire logic                 ext_reset_pin_n,
	input  wire logic [7:0]           cfg_bandgap_trim_word,
	input  wire logic [7:0]           cfg_oscillator_trim_word,
	input  wire logic [7:0]           cfg_protection_reset_word,
	output logic                      watchdog_run,
	output logic                      watchdog_clear_strobe,
	output logic                      timer3_clear_strobe,
	output logic                      bandgap_pin_output,
	output logic                      bandgap_enable,
	output logic                      conversion_start_flag,
	output logic                      pwm0_hold_clear,
	output logic      [6:1]           pwm_group_hold_clear,
	output logic                      wide_muldiv_select,
	output logic                      long_divide_select,
	output logic                      dptr_select,
	output logic                      power_save,
	output logic                      flash_write_timeout,
	output logic                      code_protect,
	output logic                      reset_pin_enable,
	output logic                      ext_reset_req,
	output logic      [3:0]           brownout_level_runtime,
	output logic      [3:0]           brownout_level_config,
	output logic      [6:0]           oscillator_trim,
	output logic      [4:0]           bandgap_trim
);
	import auxc_pkg::*;

	auxc_state_t state;
	auxc_state_t next_state;
	logic [12:0] index;
	logic        access;
	logic        wr_en;
	logic [7:0]  wbyte;
	logic [7:0]  rbyte;
	logic        fw_timeout_pulse;
	logic        reset_pin_sync;
	logic        low_power;
	logic [1:0]  wd_mode;

	////////////////////////////////////////////////////////////////////////////
	// Helpers.

	auxc_fw_timer #(
		.T1_CYC (FW_T1_CYCLES),
		.T2_CYC (FW_T2_CYCLES),
		.T3_CYC (FW_T3_CYCLES)
	) u_fw_timer (
		.clk     (clk),
		.rst     (rst),
		.busy    (flash_write_busy),
		.sel     (state.ctrl_b[B_FW_SEL_HI:B_FW_SEL_LO]),
		.timeout (fw_timeout_pulse)
	);

	auxc_sync #(
		.WIDTH (1)
	) u_reset_pin_sync (
		.clk      (clk),
		.rst      (rst),
		.async_in (~ext_reset_pin_n),
		.sync_out (reset_pin_sync)
	);

	////////////////////////////////////////////////////////////////////////////
	// Bus decode.

	assign index  = avs_address[14:2];
	assign access = avs_read | avs_write;
	assign wbyte  = avs_writedata[7:0];
	// A write lands at the edge where waitrequest is seen low.
	assign wr_en  = avs_write && state.bus == AUXC_BUS_ACK && avs_byteenable[0];

	always_comb begin
		if (index == IDX_CTRL_A) begin
			rbyte = state.ctrl_a;
		end else if (index == IDX_CTRL_B) begin
			rbyte = state.ctrl_b;
		end else if (index == IDX_STATUS) begin
			rbyte = {7'h00, state.fw_timeout};
		end else if (index == IDX_BROWNOUT) begin
			rbyte = {4'h0, state.brownout};
		end else if (index == IDX_BG_TRIM) begin
			rbyte = state.bg_word;
		end else if (index == IDX_OSC_TRIM) begin
			rbyte = state.osc_word;
		end else if (index == IDX_PROTECT) begin
			rbyte = state.protect_word;
		end else begin
			rbyte = 8'h00;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Next state.

	always_comb begin
		next_state = state;

		case (state.bus)
			AUXC_BUS_IDLE: begin
				if (access) begin
					next_state.bus   = AUXC_BUS_ACK;
					next_state.rdata = {24'h000000, rbyte};
				end
			end
			AUXC_BUS_ACK: begin
				next_state.bus = AUXC_BUS_IDLE;
			end
			default: begin
				next_state.bus = AUXC_BUS_IDLE;
			end
		endcase

		// The configuration words are captured once after reset release.
		if (!state.loaded) begin
			next_state.loaded       = 1'b1;
			next_state.bg_word      = cfg_bandgap_trim_word;
			next_state.osc_word     = cfg_oscillator_trim_word;
			next_state.protect_word = cfg_protection_reset_word;
			next_state.brownout     = cfg_protection_reset_word[P_LEVEL_HI:P_LEVEL_LO];
		end

		// Strobes last exactly one cycle after the write that set them.
		next_state.ctrl_a[A_WD_CLEAR] = 1'b0;
		next_state.ctrl_a[A_T3_CLEAR] = 1'b0;

		// End of conversion clears the start flag unless software sets it now.
		if (adc_conv_done) begin
			next_state.ctrl_a[A_CONV_START] = 1'b0;
		end

		if (wr_en && index == IDX_CTRL_A) begin
			next_state.ctrl_a[A_WD_CLEAR]   = wbyte[A_WD_CLEAR];
			next_state.ctrl_a[A_T3_CLEAR]   = wbyte[A_T3_CLEAR];
			next_state.ctrl_a[A_BG_FORCE]   = wbyte[A_BG_FORCE];
			next_state.ctrl_a[A_PWM0_HOLD]  = wbyte[A_PWM0_HOLD];
			next_state.ctrl_a[A_PWMG_HOLD]  = wbyte[A_PWMG_HOLD];
			next_state.ctrl_a[A_DPTR_SEL]   = wbyte[A_DPTR_SEL];
			if (wbyte[A_CONV_START]) begin
				next_state.ctrl_a[A_CONV_START] = 1'b1;
			end else begin
				next_state.ctrl_a[A_CONV_START] = 1'b0;
			end
		end

		if (wr_en && index == IDX_CTRL_B) begin
			next_state.ctrl_b = wbyte;
		end

		if (wr_en && index == IDX_BROWNOUT) begin
			next_state.brownout = wbyte[3:0];
		end

		// Timeout flag: write one to clear, a new timeout in the same cycle wins.
		if (wr_en && index == IDX_STATUS && wbyte[S_FW_TIMEOUT]) begin
			next_state.fw_timeout = 1'b0;
		end
		if (fw_timeout_pulse) begin
			next_state.fw_timeout = 1'b1;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// State register.

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state              <= '0;
			state.bus          <= AUXC_BUS_IDLE;
			state.ctrl_a       <= CTRL_A_RST;
			state.ctrl_b       <= CTRL_B_RST;
			state.brownout     <= BROWNOUT_RST;
		end else begin
			state <= next_state;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// Bus outputs.

	assign avs_waitrequest = access && state.bus != AUXC_BUS_ACK;
	assign avs_readdata    = state.rdata;

	////////////////////////////////////////////////////////////////////////////
	// Control outputs.

	assign wd_mode   = state.ctrl_b[B_WD_MODE_HI:B_WD_MODE_LO];
	assign low_power = power_mode == AUXC_PM_IDLE || power_mode == AUXC_PM_HALT || power_mode == AUXC_PM_STOP;

	always_comb begin
		if (wd_mode == WD_MODE_ALWAYS) begin
			watchdog_run = 1'b1;
		end else if (wd_mode == WD_MODE_ACTIVE) begin
			watchdog_run = ~low_power;
		end else begin
			watchdog_run = 1'b0;
		end
	end

	always_comb begin
		if (state.ctrl_a[A_BG_FORCE]) begin
			bandgap_enable = ~low_power;
		end else begin
			bandgap_enable = bandgap_auto_req;
		end
	end

	assign watchdog_clear_strobe = state.ctrl_a[A_WD_CLEAR];
	assign timer3_clear_strobe   = state.ctrl_a[A_T3_CLEAR];
	assign bandgap_pin_output    = state.ctrl_b[B_BG_PIN_OUT] && adc_channel_select == BG_PIN_CHAN;
	assign conversion_start_flag = state.ctrl_a[A_CONV_START];
	assign pwm0_hold_clear       = state.ctrl_a[A_PWM0_HOLD];
	assign pwm_group_hold_clear  = {6{state.ctrl_a[A_PWMG_HOLD]}};
	assign wide_muldiv_select    = state.ctrl_b[B_WIDE_MULDIV];
	assign long_divide_select    = state.ctrl_b[B_WIDE_MULDIV] & state.ctrl_b[B_LONG_DIV];
	assign dptr_select           = state.ctrl_a[A_DPTR_SEL];
	assign power_save            = state.ctrl_b[B_POWER_SAVE];
	assign flash_write_timeout   = state.fw_timeout;

	////////////////////////////////////////////////////////////////////////////
	// Configuration word fields; reserved bits 1 and 0 drive nothing.

	assign code_protect           = state.protect_word[P_PROTECT];
	assign reset_pin_enable       = state.protect_word[P_RESET_PIN];
	assign ext_reset_req          = reset_pin_sync & state.protect_word[P_RESET_PIN];
	assign brownout_level_config  = state.protect_word[P_LEVEL_HI:P_LEVEL_LO];
	assign brownout_level_runtime = state.brownout;
	assign oscillator_trim        = state.osc_word[6:0];
	assign bandgap_trim           = state.bg_word[4:0];

endmodule : auxc_ctrl

// file: hw/auxc_fw_timer.sv
module auxc_fw_timer #(
	parameter int T1_CYC = auxc_pkg::FW_T1_CYC,
	parameter int T2_CYC = auxc_pkg::FW_T2_CYC,
	parameter int T3_CYC = auxc_pkg::FW_T3_CYC
) (
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       busy,
	input  wire logic [1:0] sel,
	output logic            timeout
);
	import auxc_pkg::*;

	auxc_fwt_state_t     state;
	auxc_fwt_state_t     next_state;
	logic [FW_CNT_W-1:0] limit;

	// Counting stops at the limit so that one write yields one timeout pulse.
	always_comb begin
		next_state = state;
		next_state.timeout = 1'b0;
		case (sel)
			2'h1:    limit = FW_CNT_W'(T1_CYC - 1);
			2'h2:    limit = FW_CNT_W'(T2_CYC - 1);
			default: limit = FW_CNT_W'(T3_CYC - 1);
		endcase
		if (!busy || sel == 2'h0) begin
			next_state.count = '0;
		end else if (state.count == limit) begin
			if (!state.timeout) begin
				next_state.count = state.count;
			end
		end else begin
			next_state.count = state.count + FW_CNT_W'(1);
			if (state.count + FW_CNT_W'(1) == limit) begin
				next_state.timeout = 1'b1;
			end
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state <= '0;
		end else begin
			state <= next_state;
		end
	end

	assign timeout = state.timeout;

endmodule : auxc_fw_timer

// file: hw/auxc_pkg.sv
package auxc_pkg;

	////////////////////////////////////////////////////////////////////////////
	// Clock and timing.

	localparam int        CLK_MHZ       = 40;
	localparam real       FW_T1_MS      = 1.6;
	localparam real       FW_T2_MS      = 3.2;
	localparam real       FW_T3_MS      = 12.8;
	localparam int        FW_T1_CYC     = int'(FW_T1_MS * 1000.0 * CLK_MHZ);
	localparam int        FW_T2_CYC     = int'(FW_T2_MS * 1000.0 * CLK_MHZ);
	localparam int        FW_T3_CYC     = int'(FW_T3_MS * 1000.0 * CLK_MHZ);
	localparam int        FW_CNT_W      = 20;

	////////////////////////////////////////////////////////////////////////////
	// Register indices; the byte address is four times the index.

	localparam logic [12:0] IDX_CTRL_A    = 13'h00F8;
	localparam logic [12:0] IDX_CTRL_B    = 13'h00F7;
	localparam logic [12:0] IDX_STATUS    = 13'h00F9;
	localparam logic [12:0] IDX_BROWNOUT  = 13'h00E3;
	localparam logic [12:0] IDX_BG_TRIM   = 13'h1FFB;
	localparam logic [12:0] IDX_OSC_TRIM  = 13'h1FFD;
	localparam logic [12:0] IDX_PROTECT   = 13'h1FFF;

	////////////////////////////////////////////////////////////////////////////
	// Field positions.

	localparam int A_WD_CLEAR    = 7;
	localparam int A_T3_CLEAR    = 6;
	localparam int A_BG_FORCE    = 5;
	localparam int A_CONV_START  = 4;
	localparam int A_PWM0_HOLD   = 3;
	localparam int A_PWMG_HOLD   = 2;
	localparam int A_DPTR_SEL    = 0;
	localparam int B_WD_MODE_HI  = 7;
	localparam int B_WD_MODE_LO  = 6;
	localparam int B_POWER_SAVE  = 5;
	localparam int B_BG_PIN_OUT  = 4;
	localparam int B_LONG_DIV    = 3;
	localparam int B_FW_SEL_HI   = 2;
	localparam int B_FW_SEL_LO   = 1;
	localparam int B_WIDE_MULDIV = 0;
	localparam int S_FW_TIMEOUT  = 0;
	localparam int P_PROTECT     = 7;
	localparam int P_RESET_PIN   = 6;
	localparam int P_LEVEL_HI    = 5;
	localparam int P_LEVEL_LO    = 2;

	////////////////////////////////////////////////////////////////////////////
	// Reset values and codes.

	localparam logic [7:0] CTRL_A_RST    = 8'h0C;
	localparam logic [7:0] CTRL_B_RST    = 8'h06;
	localparam logic [3:0] BROWNOUT_RST  = 4'h0;
	localparam logic [3:0] BG_PIN_CHAN   = 4'hC;
	localparam logic [1:0] WD_MODE_ALWAYS = 2'h3;
	localparam logic [1:0] WD_MODE_ACTIVE = 2'h2;

	typedef enum logic [2:0] {
		AUXC_PM_FAST = 3'h0,
		AUXC_PM_SLOW = 3'h1,
		AUXC_PM_IDLE = 3'h2,
		AUXC_PM_HALT = 3'h3,
		AUXC_PM_STOP = 3'h4
	} auxc_power_t;

	typedef enum logic [1:0] {
		AUXC_BUS_IDLE = 2'b01,
		AUXC_BUS_ACK  = 2'b10
	} auxc_bus_t;

	typedef struct packed {
		auxc_bus_t   bus;
		logic [7:0]  ctrl_a;
		logic [7:0]  ctrl_b;
		logic [3:0]  brownout;
		logic        fw_timeout;
		logic [7:0]  bg_word;
		logic [7:0]  osc_word;
		logic [7:0]  protect_word;
		logic        loaded;
		logic [31:0] rdata;
	} auxc_state_t;

	typedef struct packed {
		logic [FW_CNT_W-1:0] count;
		logic                timeout;
	} auxc_fwt_state_t;

	typedef struct packed {
		logic first;
		logic second;
	} auxc_sync_state_t;

endpackage : auxc_pkg

// file: hw/auxc_sync.sv
module auxc_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst,
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	import auxc_pkg::*;

	genvar i;
	generate
		for (i = 0; i < WIDTH; i++) begin : g_bit
			auxc_sync_state_t state;
			auxc_sync_state_t next_state;

			always_comb begin
				next_state.first  = async_in[i];
				next_state.second = state.first;
			end

			always_ff @(posedge clk or posedge rst) begin
				if (rst) begin
					state <= '0;
				end else begin
					state <= next_state;
				end
			end

			assign sync_out[i] = state.second;
		end
	endgenerate

endmodule : auxc_sync

// file: verification/auxc_ctrl_chk.sv
module auxc_ctrl_chk (
	input wire logic                  clk,
	input wire logic                  rst,
	input wire logic [14:0]           avs_address,
	input wire logic                  avs_write,
	input wire logic [3:0]            avs_byteenable,
	input wire logic [31:0]           avs_writedata,
	input wire logic                  avs_waitrequest,
	input wire auxc_pkg::auxc_power_t power_mode,
	input wire logic [3:0]            adc_channel_select,
	input wire logic                  adc_conv_done,
	input wire logic                  ext_reset_pin_n,
	input wire logic [7:0]            cfg_oscillator_trim_word,
	input wire logic [7:0]            cfg_protection_reset_word,
	input wire logic                  watchdog_run,
	input wire logic                  watchdog_clear_strobe,
	input wire logic                  timer3_clear_strobe,
	input wire logic                  bandgap_pin_output,
	input wire logic                  conversion_start_flag,
	input wire logic                  pwm0_hold_clear,
	input wire logic [6:1]            pwm_group_hold_clear,
	input wire logic                  wide_muldiv_select,
	input wire logic                  long_divide_select,
	input wire logic                  code_protect,
	input wire logic                  reset_pin_enable,
	input wire logic                  ext_reset_req,
	input wire logic [3:0]            brownout_level_config,
	input wire logic [6:0]            oscillator_trim
);
	import auxc_pkg::*;

	typedef struct packed {
		logic [7:0] b;
		logic [1:0] age;
	} auxc_chk_state_t;

	auxc_chk_state_t st;
	auxc_chk_state_t next_st;
	logic            wr_a;
	logic            wr_b;

	// Mirror of the accepted bus writes to IDX_CTRL_B, so that decoded outputs can be tied to the written bits.
	assign wr_a = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[14:2] == IDX_CTRL_A;
	assign wr_b = avs_write && !avs_waitrequest && avs_byteenable[0] && avs_address[14:2] == IDX_CTRL_B;

	always_comb begin
		next_st = st;
		if (wr_b) begin
			next_st.b = avs_writedata[7:0];
		end
		if (st.age != 2'h2) begin
			next_st.age = st.age + 2'h1;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			st <= '{b: 8'h06, age: 2'h0};
		end else begin
			st <= next_st;
		end
	end

	////////////////////////////////////////////////////////////////////////////

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	sequence s_pulse(logic s);
		s ##1 !s;
	endsequence

	sequence s_pin_low;
		!ext_reset_pin_n [*3];
	endsequence

	AST_WD_ALWAYS: assert property (st.b[7:6] == 2'h3 |-> watchdog_run)
		else $error("watchdog stopped in always-on mode");
	AST_WD_OFF: assert property (!st.b[7] |-> !watchdog_run)
		else $error("watchdog running while disabled");
	AST_WD_ACTIVE: assert property (st.b[7:6] == 2'h2 |->
		watchdog_run == (power_mode inside {AUXC_PM_FAST, AUXC_PM_SLOW})) else $error("watchdog active-mode gating wrong");
	AST_BG_PIN: assert property (bandgap_pin_output == (st.b[4] && adc_channel_select == 4'hC))
		else $error("bandgap pin routing wrong");
	AST_DIVIDE: assert property (wide_muldiv_select == st.b[0] && long_divide_select == (st.b[3] && st.b[0]))
		else $error("multiply divide width wrong");
	AST_WD_CLEAR: assert property (wr_a && avs_writedata[7] |=> s_pulse(watchdog_clear_strobe))
		else $error("watchdog clear strobe not one cycle");
	AST_T3_CLEAR: assert property (wr_a && avs_writedata[6] |=> s_pulse(timer3_clear_strobe))
		else $error("timer3 clear strobe not one cycle");
	AST_CONV_WRITE: assert property (wr_a |=> conversion_start_flag == $past(avs_writedata[4]))
		else $error("conversion start does not follow write");
	AST_CONV_DONE: assert property (adc_conv_done && !wr_a |=> !conversion_start_flag)
		else $error("conversion start not cleared at end");
	AST_PWM_HOLD: assert property (wr_a |=> pwm0_hold_clear == $past(avs_writedata[3])
		&& pwm_group_hold_clear == {6{$past(avs_writedata[2])}}) else $error("pwm hold bits wrong");
	AST_CFG: assert property (st.age == 2'h2 |-> code_protect == cfg_protection_reset_word[7]
		&& brownout_level_config == cfg_protection_reset_word[5:2] && oscillator_trim == cfg_oscillator_trim_word[6:0])
		else $error("configuration fields wrong");
	AST_EXT_RESET: assert property (st.age == 2'h2 ##0 s_pin_low ##0 reset_pin_enable |-> ext_reset_req)
		else $error("external reset not requested");

endmodule : auxc_ctrl_chk

bind auxc_ctrl auxc_ctrl_chk chk (.*);

// file: verification/auxc_ctrl_tb.sv
module auxc_ctrl_tb;
	timeunit 1ns;
	timeprecision 1ps;
	import auxc_pkg::*;

	localparam int T1 = 8;

	logic        clk = 1'b0, rst = 1'b1, avs_read = 1'b0, avs_write = 1'b0, conv_slow = 1'b0;
	logic [14:0] avs_address = 15'h0000;
	logic [3:0]  avs_byteenable = 4'h1, adc_channel_select = 4'h0, brownout_level_runtime, brownout_level_config;
	logic [31:0] avs_writedata = 32'h0, avs_readdata, q;
	logic        avs_waitrequest, adc_conv_done, bandgap_auto_req = 1'b0, flash_write_busy = 1'b0;
	logic        ext_reset_pin_n = 1'b1, watchdog_run, watchdog_clear_strobe, timer3_clear_strobe;
	logic        bandgap_pin_output, bandgap_enable, conversion_start_flag, pwm0_hold_clear, dptr_select;
	logic        wide_muldiv_select, long_divide_select, power_save, flash_write_timeout;
	logic        code_protect, reset_pin_enable, ext_reset_req;
	logic [7:0]  cfg_bandgap_trim_word, cfg_oscillator_trim_word, cfg_protection_reset_word;
	logic [6:1]  pwm_group_hold_clear;
	logic [6:0]  oscillator_trim;
	logic [4:0]  bandgap_trim;
	auxc_power_t power_mode = AUXC_PM_FAST;
	int          num_errors = 0, n_checks = 0, n_strobe = 0;

	always #12.5 clk = ~clk;

	auxc_ctrl #(.FW_T1_CYCLES(T1), .FW_T2_CYCLES(16), .FW_T3_CYCLES(32)) dut (.*);
	auxc_periph_model peer (.*);

	// Counts cycles in which both clear strobes stand together.
	always @(posedge clk) begin
		if (watchdog_clear_strobe === 1'b1 && timer3_clear_strobe === 1'b1) n_strobe <= n_strobe + 1;
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_checks++;
		if (seen !== exp) begin
			num_errors++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk

	// Starts right after a rising edge, holds the request until waitrequest is seen low at a rising edge,
	// takes read data at that edge, releases, and lets one idle edge pass.
	task automatic xfer(input logic wr, input logic [12:0] idx, input logic [7:0] d, input logic [3:0] be);
		int n;
		n = 0;
		avs_address <= {idx, 2'b00};
		avs_write <= wr;
		avs_read <= !wr;
		avs_writedata <= {24'h0, d};
		avs_byteenable <= be;
		@(posedge clk);
		while (avs_waitrequest !== 1'b0 && n < 20) begin
			n++;
			@(posedge clk);
		end
		if (n == 20) begin
			num_errors++;
			end_of_test();
		end
		q = avs_readdata;
		avs_read <= 1'b0;
		avs_write <= 1'b0;
		@(posedge clk);
	endtask : xfer

	task automatic wr(input logic [12:0] idx, input logic [7:0] d);
		xfer(1'b1, idx, d, 4'h1);
	endtask : wr

	task automatic rd(input logic [12:0] idx);
		xfer(1'b0, idx, 8'h00, 4'h1);
	endtask : rd

	task automatic end_of_test();
		$display("checks=%0d errors=%0d", n_checks, num_errors);
		if (num_errors == 0 && n_checks > 0) $display("STATUS OK");
		else $display("STATUS NOT OK");
		$finish;
	endtask : end_of_test

	initial begin
		repeat (20000) @(posedge clk);
		num_errors++;
		end_of_test();
	end

	initial begin
		repeat (6) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		rd(IDX_CTRL_A);
		chk(q, 32'h0C);
		rd(IDX_CTRL_B);
		chk(q, 32'h06);
		rd(IDX_BROWNOUT);
		chk(q & 32'hF, 32'h6);
		chk({code_protect, reset_pin_enable, brownout_level_config}, 6'h36);
		chk(oscillator_trim, 7'h45);
		chk(bandgap_trim, 5'h0A);
		chk({pwm0_hold_clear, pwm_group_hold_clear}, 7'h7F);
		wr(IDX_OSC_TRIM, 8'h00);
		chk(oscillator_trim, 7'h45);
		rd(13'h0100);
		chk(q, 32'h0);
		xfer(1'b1, IDX_CTRL_B, 8'hFF, 4'h0);
		rd(IDX_CTRL_B);
		chk(q, 32'h06);
		for (int m = 0; m < 4; m++) begin
			wr(IDX_CTRL_B, {m[1:0], 6'h06});
			for (int p = 0; p < 5; p++) begin
				power_mode <= auxc_power_t'(p);
				@(negedge clk);
				chk(watchdog_run, m[1] && (m[0] || p < 2));
				@(posedge clk);
			end
		end
		power_mode <= AUXC_PM_FAST;
		for (int k = 0; k < 16; k++) begin
			adc_channel_select <= k[3] ? 4'hC : 4'hB;
			wr(IDX_CTRL_B, {3'h0, k[2], k[1], 2'h3, k[0]});
			chk(bandgap_pin_output, k[3] && k[2]);
			chk({wide_muldiv_select, long_divide_select}, {k[0], k[1] && k[0]});
		end
		for (int k = 0; k < 20; k++) begin
			logic f;
			logic a;
			f = k >= 10;
			a = (k / 5) % 2 == 1;
			if (k % 5 == 0) wr(IDX_CTRL_A, {2'h0, f, 5'h0C});
			power_mode <= auxc_power_t'(k % 5);
			bandgap_auto_req <= a;
			@(negedge clk);
			if (!(f && a && k % 5 > 1)) chk(bandgap_enable, (f && k % 5 < 2) || a);
			@(posedge clk);
		end
		power_mode <= AUXC_PM_FAST;
		bandgap_auto_req <= 1'b0;
		wr(IDX_CTRL_A, 8'hC1);
		@(negedge clk);
		chk(n_strobe, 1);
		@(posedge clk);
		chk({pwm0_hold_clear, pwm_group_hold_clear, dptr_select}, 8'h01);
		rd(IDX_CTRL_A);
		chk(q, 32'h01);
		conv_slow <= 1'b1;
		wr(IDX_CTRL_A, 8'h10);
		rd(IDX_CTRL_A);
		chk(q, 32'h10);
		wr(IDX_CTRL_A, 8'h00);
		chk(conversion_start_flag, 1'b0);
		conv_slow <= 1'b0;
		wr(IDX_CTRL_A, 8'h10);
		for (int n = 0; n < 20 && conversion_start_flag; n++) @(posedge clk);
		@(negedge clk);
		chk(conversion_start_flag, 1'b0);
		@(posedge clk);
		wr(IDX_CTRL_B, 8'h22);
		chk(power_save, 1'b1);
		flash_write_busy <= 1'b1;
		repeat (T1 - 2) @(posedge clk);
		@(negedge clk);
		chk(flash_write_timeout, 1'b0);
		repeat (4) @(posedge clk);
		flash_write_busy <= 1'b0;
		@(negedge clk);
		chk(flash_write_timeout, 1'b1);
		@(posedge clk);
		wr(IDX_STATUS, 8'h01);
		chk(flash_write_timeout, 1'b0);
		wr(IDX_CTRL_B, 8'h00);
		flash_write_busy <= 1'b1;
		repeat (T1 + 4) @(posedge clk);
		flash_write_busy <= 1'b0;
		@(negedge clk);
		chk(flash_write_timeout, 1'b0);
		@(posedge clk);
		ext_reset_pin_n <= 1'b0;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(ext_reset_req, 1'b1);
		@(posedge clk);
		ext_reset_pin_n <= 1'b1;
		repeat (4) @(posedge clk);
		@(negedge clk);
		chk(ext_reset_req, 1'b0);
		end_of_test();
	end

endmodule : auxc_ctrl_tb

// file: verification/auxc_periph_model.sv
module auxc_periph_model #(
	parameter logic [7:0] BG_WORD   = 8'hEA,
	parameter logic [7:0] OSC_WORD  = 8'hC5,
	parameter logic [7:0] CODE_PROTECT_WORD = 8'hDB
) (
	input wire logic  clk,
	input wire logic  rst,
	input wire logic  conv_slow,
	input wire logic  conversion_start_flag,
	output logic      adc_conv_done,
	output logic [7:0] cfg_bandgap_trim_word,
	output logic [7:0] cfg_oscillator_trim_word,
	output logic [7:0] cfg_protection_reset_word
);
	timeunit 1ns;
	timeprecision 1ps;

	logic [7:0] cnt;

	// Flash contents; the two low protection bits are set so that reserved bits must be ignored.
	assign cfg_bandgap_trim_word     = BG_WORD;
	assign cfg_oscillator_trim_word  = OSC_WORD;
	assign cfg_protection_reset_word = CODE_PROTECT_WORD;

	// The converter ends a started conversion with a one-cycle done pulse, promptly or slowly.
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			cnt <= 8'h00;
			adc_conv_done <= 1'b0;
		end else begin
			adc_conv_done <= 1'b0;
			if (!conversion_start_flag || adc_conv_done) begin
				cnt <= 8'h00;
			end else if (cnt == (conv_slow ? 8'h28 : 8'h02)) begin
				adc_conv_done <= 1'b1;
				cnt <= 8'h00;
			end else begin
				cnt <= cnt + 8'h01;
			end
		end
	end

endmodule : auxc_periph_model
